// File: verilog/rrse_core.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module rrse_core #(
  parameter int STACK_DEPTH = rrse_pkg::RRSE_STACK_DEPTH,
  parameter int FILE_WORDS = rrse_pkg::RRSE_FILE_WORDS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // wake and status pins
  input wire logic wake_req,
  output logic sleeping,
  output logic [1:0] phase
);
  import rrse_pkg::*;

  localparam int SPW = $clog2(STACK_DEPTH);

  logic [7:0] file_mem [FILE_WORDS];
  logic [12:0] stack_mem [STACK_DEPTH];

  rrse_state_t state, next_state;
  rrse_instr_t instr, next_instr;
  rrse_status_t st, next_st;
  logic [7:0] acc, next_acc;
  logic [12:0] pc, next_pc;
  logic [SPW-1:0] sp, next_sp;
  logic [7:0] wdog, next_wdog;
  logic [7:0] presc, next_presc;
  logic [31:0] next_prdata;

  logic run, cycle_end, busy;
  logic setup, access, wr_ok, bad_addr;
  logic go_take, exec_fire, wdog_ovf;
  logic [7:0] src, file_wd;
  logic [6:0] file_wa;
  logic file_we, push_we;
  logic [12:0] top_of_stack_entry;

  function automatic logic known_addr(input logic [7:0] a);
    return a == RRSE_CTRL_OFF || a == RRSE_ACC_OFF || a == RRSE_FILE_OFF ||
           a == RRSE_STATUS_OFF || a == RRSE_PC_OFF || a == RRSE_STACK_OFF ||
           a == RRSE_WDOG_OFF;
  endfunction : known_addr

  function automatic logic is_return(input rrse_op_t op);
    return op == RRSE_OP_RET_SUB || op == RRSE_OP_RET_LIT || op == RRSE_OP_RET_INT;
  endfunction : is_return

  // phase clock stops in sleep and idle
  assign run = (state == RRSE_ST_EXEC) || (state == RRSE_ST_FLUSH);

  rrse_phase u_phase (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(run),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  assign busy = state != RRSE_ST_IDLE;
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign bad_addr = !known_addr(paddr);
  // writes are refused while an instruction is in flight
  assign wr_ok = access && pwrite && !busy && !bad_addr;
  assign pready = 1'b1;
  assign pslverr = access && (bad_addr || (pwrite && busy));
  assign go_take = wr_ok && paddr == RRSE_CTRL_OFF && pwdata[RRSE_CTRL_GO_BIT];
  assign exec_fire = state == RRSE_ST_EXEC && cycle_end;
  assign src = file_mem[instr.faddr];
  assign top_of_stack_entry = stack_mem[sp - SPW'(1)];
  // watchdog keeps its own clock, so it also counts in sleep
  assign wdog_ovf = wdog == 8'hFF && presc == 8'hFF;
  assign sleeping = state == RRSE_ST_SLEEP;

  always_comb begin
    next_state = state;
    next_instr = instr;
    next_st = st;
    next_acc = acc;
    next_pc = pc;
    next_sp = sp;
    next_presc = presc + 8'h01;
    next_wdog = (presc == 8'hFF) ? wdog + 8'h01 : wdog;
    file_we = 1'b0;
    file_wa = instr.faddr;
    file_wd = pwdata[7:0];
    push_we = 1'b0;
    if (wdog_ovf) begin
      next_st.timeout_flag = 1'b0;
    end
    case (state)
      RRSE_ST_IDLE: begin
        if (go_take) begin
          next_instr = rrse_instr_t'(pwdata[$bits(rrse_instr_t)-1:0]);
          next_state = RRSE_ST_EXEC;
        end
      end
      RRSE_ST_EXEC: begin
        if (cycle_end) begin
          next_state = RRSE_ST_IDLE;
          case (instr.op)
            RRSE_OP_ROT_LEFT, RRSE_OP_ROT_RIGHT: begin
              if (instr.op == RRSE_OP_ROT_LEFT) begin
                file_wd = {src[6:0], st.carry};
                next_st.carry = src[7];
              end else begin
                file_wd = {st.carry, src[7:1]};
                next_st.carry = src[0];
              end
              if (instr.dest) begin
                file_we = 1'b1;
              end else begin
                next_acc = file_wd;
              end
            end
            RRSE_OP_RET_SUB, RRSE_OP_RET_LIT, RRSE_OP_RET_INT: begin
              next_pc = top_of_stack_entry;
              next_sp = sp - SPW'(1);
              next_state = RRSE_ST_FLUSH;
              if (instr.op == RRSE_OP_RET_LIT) begin
                next_acc = instr.literal;
              end
              if (instr.op == RRSE_OP_RET_INT) begin
                next_st.global_interrupt_enable = 1'b1;
              end
            end
            RRSE_OP_POWER_DOWN: begin
              next_wdog = RRSE_WDOG_CLEAR;
              next_presc = 8'h00;
              next_st.power_down_flag = 1'b0;
              next_st.timeout_flag = 1'b1;
              next_state = RRSE_ST_SLEEP;
            end
            default: begin
            end
          endcase
          if (instr.op != RRSE_OP_RET_SUB && instr.op != RRSE_OP_RET_LIT &&
              instr.op != RRSE_OP_RET_INT) begin
            next_pc = pc + 13'h0001;
          end
        end
      end
      RRSE_ST_FLUSH: begin
        // dummy fetch from the restored counter
        if (cycle_end) begin
          next_state = RRSE_ST_IDLE;
        end
      end
      RRSE_ST_SLEEP: begin
        if (wake_req || wdog_ovf) begin
          next_state = RRSE_ST_IDLE;
          next_pc = pc + 13'h0001;
        end
      end
      default: begin
        next_state = RRSE_ST_IDLE;
      end
    endcase
    if (wr_ok) begin
      case (paddr)
        RRSE_ACC_OFF: next_acc = pwdata[7:0];
        RRSE_FILE_OFF: file_we = 1'b1;
        RRSE_STATUS_OFF: begin
          next_st.carry = pwdata[RRSE_ST_CARRY_BIT];
          next_st.global_interrupt_enable = pwdata[RRSE_ST_GIE_BIT];
        end
        RRSE_PC_OFF: next_pc = pwdata[12:0];
        RRSE_STACK_OFF: begin
          push_we = 1'b1;
          next_sp = sp + SPW'(1);
        end
        RRSE_CTRL_OFF: begin
          if (!pwdata[RRSE_CTRL_GO_BIT]) begin
            next_instr = rrse_instr_t'(pwdata[$bits(rrse_instr_t)-1:0]);
          end
        end
        default: begin
        end
      endcase
    end
    next_st.busy = next_state != RRSE_ST_IDLE;
    next_st.sleeping = next_state == RRSE_ST_SLEEP;
  end

  // read data captured in setup, shown in the zero-wait access phase
  always_comb begin
    next_prdata = 32'h00000000;
    if (setup && !pwrite) begin
      case (paddr)
        RRSE_CTRL_OFF: next_prdata = 32'(instr);
        RRSE_ACC_OFF: next_prdata = {24'h000000, acc};
        RRSE_FILE_OFF: next_prdata = {24'h000000, src};
        RRSE_STATUS_OFF: next_prdata = 32'(st);
        RRSE_PC_OFF: next_prdata = {19'h00000, pc};
        RRSE_STACK_OFF: next_prdata = {13'h0000, 3'(sp), 3'h0, top_of_stack_entry};
        RRSE_WDOG_OFF: next_prdata = {16'h0000, wdog, presc};
        default: next_prdata = 32'h00000000;
      endcase
    end else if (access) begin
      next_prdata = prdata;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= RRSE_ST_IDLE;
      instr <= '0;
      st <= '{sleeping: 1'b0, busy: 1'b0, timeout_flag: 1'b1, power_down_flag: 1'b1,
              global_interrupt_enable: 1'b0, carry: 1'b0};
      acc <= RRSE_ACC_RST;
      pc <= RRSE_PC_RST;
      sp <= '0;
      wdog <= RRSE_WDOG_CLEAR;
      presc <= 8'h00;
      prdata <= 32'h00000000;
    end else begin
      state <= next_state;
      instr <= next_instr;
      st <= next_st;
      acc <= next_acc;
      pc <= next_pc;
      sp <= next_sp;
      wdog <= next_wdog;
      presc <= next_presc;
      prdata <= next_prdata;
    end
  end

  // storage arrays carry no reset
  always_ff @(posedge sys_clk) begin
    if (file_we) begin
      file_mem[file_wa] <= file_wd;
    end
    if (push_we) begin
      stack_mem[sp] <= pwdata[12:0];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_rot_left;
    exec_fire && instr.op == RRSE_OP_ROT_LEFT && !instr.dest |=>
      acc == {$past(src[6:0]), $past(st.carry)} && st.carry == $past(src[7]);
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate left result wrong");

  property p_rot_right;
    exec_fire && instr.op == RRSE_OP_ROT_RIGHT && !instr.dest |=>
      acc == {$past(st.carry), $past(src[7:1])} && st.carry == $past(src[0]);
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("rotate right result wrong");

  property p_rot_dest;
    exec_fire && (instr.op == RRSE_OP_ROT_LEFT || instr.op == RRSE_OP_ROT_RIGHT) && instr.dest
      |-> file_we && file_wa == instr.faddr ##1 $stable(acc);
  endproperty
  a_rot_dest: assert property (p_rot_dest) else $error("rotate destination wrong");

  property p_ret_lit;
    exec_fire && instr.op == RRSE_OP_RET_LIT |=>
      acc == $past(instr.literal) && $stable(st.carry) && $stable(st.power_down_flag);
  endproperty
  a_ret_lit: assert property (p_ret_lit) else $error("literal return wrong");

  property p_ret_pop;
    exec_fire && is_return(instr.op) |=> pc == $past(top_of_stack_entry) && sp == $past(sp) - SPW'(1);
  endproperty
  a_ret_pop: assert property (p_ret_pop) else $error("return did not pop");

  property p_ret_flags;
    exec_fire && instr.op == RRSE_OP_RET_SUB |=> $stable(st.carry) && $stable(acc) &&
      $stable(st.global_interrupt_enable);
  endproperty
  a_ret_flags: assert property (p_ret_flags) else $error("return changed flags");

  property p_ret_two_cycles;
    exec_fire && is_return(instr.op) |=> (state == RRSE_ST_FLUSH) [*4] ##1 state == RRSE_ST_IDLE;
  endproperty
  a_ret_two_cycles: assert property (p_ret_two_cycles) else $error("return not two cycles");

  property p_ret_int;
    exec_fire && instr.op == RRSE_OP_RET_INT |=> st.global_interrupt_enable && $stable(st.carry);
  endproperty
  a_ret_int: assert property (p_ret_int) else $error("interrupt return wrong");

  property p_pd_wdog;
    exec_fire && instr.op == RRSE_OP_POWER_DOWN |=> wdog == RRSE_WDOG_CLEAR && presc == 8'h00;
  endproperty
  a_pd_wdog: assert property (p_pd_wdog) else $error("watchdog not cleared");

  property p_pd_flags;
    exec_fire && instr.op == RRSE_OP_POWER_DOWN |=>
      !st.power_down_flag && st.timeout_flag && $stable(st.carry);
  endproperty
  a_pd_flags: assert property (p_pd_flags) else $error("power-down flags wrong");

  property p_sleep_still;
    state == RRSE_ST_SLEEP |-> !run && phase == 2'h0 && !exec_fire;
  endproperty
  a_sleep_still: assert property (p_sleep_still) else $error("core ran while asleep");

  property p_four_phases;
    go_take |=> (state == RRSE_ST_EXEC) [*4] ##1 state != RRSE_ST_EXEC;
  endproperty
  a_four_phases: assert property (p_four_phases) else $error("cycle not four phases");

  c_ret_lit: cover property (exec_fire && instr.op == RRSE_OP_RET_LIT);
  c_rot_file: cover property (exec_fire && instr.op == RRSE_OP_ROT_LEFT && instr.dest);
  c_sleep_wake: cover property (state == RRSE_ST_SLEEP ##1 state == RRSE_ST_IDLE);

endmodule : rrse_core

// File: verilog/rrse_pkg.sv
// Function
// - rotate left through carry moves the file byte one place up, old carry into bit 0, old bit 7 into carry.
// - rotate right through carry moves the file byte one place down, old carry into bit 7, old bit 0 into carry.
// - for both rotates destination 0 writes the result to the working accumulator and 1 writes it back to the file byte.
// - return with literal loads the 8-bit literal into the working accumulator and leaves the status flags alone.
// - return with literal loads the program counter from the top stack entry and pops that entry.
// - the plain subroutine return pops the stack into the program counter and leaves the status flags alone.
// - every return takes two instruction cycles because the next fetch uses the restored program counter.
// - power-down clears the watchdog counter to zero and clears its prescaler.
// - power-down clears the active-low power-down flag and sets the active-low timeout flag, nothing else.
// - after power-down the core sleeps with its phase clock stopped and runs nothing until it wakes.
// - one instruction cycle lasts exactly four oscillator periods, sequenced as four phases.
package rrse_pkg;

  localparam int RRSE_PHASES = 4;
  localparam int RRSE_STACK_DEPTH = 8;
  localparam int RRSE_FILE_WORDS = 128;

  // register byte offsets
  localparam logic [7:0] RRSE_CTRL_OFF = 8'h00;
  localparam logic [7:0] RRSE_ACC_OFF = 8'h04;
  localparam logic [7:0] RRSE_FILE_OFF = 8'h08;
  localparam logic [7:0] RRSE_STATUS_OFF = 8'h0C;
  localparam logic [7:0] RRSE_PC_OFF = 8'h10;
  localparam logic [7:0] RRSE_STACK_OFF = 8'h14;
  localparam logic [7:0] RRSE_WDOG_OFF = 8'h18;

  // field positions
  localparam int RRSE_CTRL_GO_BIT = 31;
  localparam int RRSE_ST_CARRY_BIT = 0;
  localparam int RRSE_ST_GIE_BIT = 1;

  // reset values
  localparam logic [7:0] RRSE_ACC_RST = 8'h00;
  localparam logic [12:0] RRSE_PC_RST = 13'h0000;
  localparam logic [7:0] RRSE_WDOG_CLEAR = 8'h00;

  typedef enum logic [2:0] {
    RRSE_OP_NOP = 3'h0,
    RRSE_OP_RET_SUB = 3'h1,
    RRSE_OP_RET_LIT = 3'h2,
    RRSE_OP_RET_INT = 3'h3,
    RRSE_OP_ROT_LEFT = 3'h4,
    RRSE_OP_ROT_RIGHT = 3'h5,
    RRSE_OP_POWER_DOWN = 3'h6
  } rrse_op_t;

  typedef struct packed {
    rrse_op_t op;
    logic dest;
    logic [6:0] faddr;
    logic [7:0] literal;
  } rrse_instr_t;

  typedef struct packed {
    logic sleeping;
    logic busy;
    logic timeout_flag;
    logic power_down_flag;
    logic global_interrupt_enable;
    logic carry;
  } rrse_status_t;

  typedef enum logic [3:0] {
    RRSE_ST_IDLE = 4'b0001,
    RRSE_ST_EXEC = 4'b0010,
    RRSE_ST_FLUSH = 4'b0100,
    RRSE_ST_SLEEP = 4'b1000
  } rrse_state_t;

endpackage : rrse_pkg

// File: verilog/rrse_phase.sv
`timescale 1ns/100ps
module rrse_phase (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // control
  input wire logic run,
  // phase outputs
  output logic [1:0] phase,
  output logic cycle_end
);
  import rrse_pkg::*;

  logic [1:0] next_phase;

  // held at phase 0 when not running, so each cycle starts aligned
  always_comb begin
    next_phase = 2'h0;
    if (run) begin
      next_phase = phase + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 2'h0;
    end else begin
      phase <= next_phase;
    end
  end

  assign cycle_end = run && (phase == 2'(RRSE_PHASES - 1));

endmodule : rrse_phase

// File: dv/test_return_rotate_sleep_exec.sv
`timescale 1ns/100ps
module test_return_rotate_sleep_exec;
  import rrse_pkg::*;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic wake_req, sleeping, err, ok;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] phase;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  rrse_core u_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_req(wake_req), .sleeping(sleeping), .phase(phase));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // the watchdog overflow wait dominates the run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  // answer taken at the edge where pready is seen high; only the timeout ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      ok = pready;
    end while (ok !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    check(ok, 1'b1);
  endtask : apb

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, RRSE_STATUS_OFF, 32'h0);
      n++;
    end while (rd[4] !== 1'b0 && n < 20);
    check(rd & 32'h10, 32'h0);
  endtask : wait_idle

  task automatic phases;
    int n;
    n = 0;
    while (phase !== 2'h1 && n < 6) begin
      @(negedge sys_clk);
      n++;
    end
    for (int p = 2; p < 5; p++) begin
      @(negedge sys_clk);
      check(phase, p % 4);
    end
  endtask : phases

  task automatic t_reset;
    apb(1'b0, RRSE_STATUS_OFF, 32'h0);
    check(rd, 32'hC);
    apb(1'b0, RRSE_ACC_OFF, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check(rd, 32'h0);
    check(err, 1'b1);
  endtask : t_reset

  task automatic t_rotate;
    logic [7:0] f, r;
    logic c, co, lft;
    logic [7:0] fi [4] = '{8'hA5, 8'h81, 8'hA5, 8'h02};
    for (int i = 0; i < 4; i++) begin
      lft = (i < 2);
      c = (i == 0 || i == 3);
      f = fi[i];
      r = lft ? {f[6:0], c} : {c, f[7:1]};
      co = lft ? f[7] : f[0];
      apb(1'b1, RRSE_CTRL_OFF, {17'h0, 5'h04, i[1:0], 8'h00});
      apb(1'b1, RRSE_FILE_OFF, {24'h0, f});
      apb(1'b1, RRSE_STATUS_OFF, {31'h0, c});
      apb(1'b1, RRSE_ACC_OFF, 32'h33);
      apb(1'b1, RRSE_CTRL_OFF, {1'b1, 12'h0, lft ? RRSE_OP_ROT_LEFT : RRSE_OP_ROT_RIGHT,
        i[0], 5'h04, i[1:0], 8'h00});
      phases();
      wait_idle();
      apb(1'b0, RRSE_ACC_OFF, 32'h0);
      check(rd, i[0] ? 32'h33 : {24'h0, r});
      apb(1'b0, RRSE_FILE_OFF, 32'h0);
      check(rd, {24'h0, i[0] ? r : f});
      apb(1'b0, RRSE_STATUS_OFF, 32'h0);
      check(rd & 32'h1, {31'h0, co});
    end
  endtask : t_rotate

  task automatic ret(input rrse_op_t op, input logic [7:0] lit);
    apb(1'b1, RRSE_CTRL_OFF, {1'b1, 12'h0, op, 8'h00, lit});
    phases();
    wait_idle();
    apb(1'b0, RRSE_PC_OFF, 32'h0);
  endtask : ret

  task automatic t_returns;
    apb(1'b1, RRSE_STACK_OFF, 32'h123);
    apb(1'b1, RRSE_STACK_OFF, 32'h456);
    apb(1'b1, RRSE_STACK_OFF, 32'h1ABC);
    apb(1'b1, RRSE_STATUS_OFF, 32'h1);
    apb(1'b1, RRSE_ACC_OFF, 32'h0);
    ret(RRSE_OP_RET_INT, 8'h00);
    check(rd, 32'h1ABC);
    apb(1'b0, RRSE_STATUS_OFF, 32'h0);
    check(rd, 32'hF);
    ret(RRSE_OP_RET_LIT, 8'hC3);
    check(rd, 32'h456);
    apb(1'b0, RRSE_ACC_OFF, 32'h0);
    check(rd, 32'hC3);
    apb(1'b0, RRSE_STATUS_OFF, 32'h0);
    check(rd, 32'hF);
    apb(1'b0, RRSE_STACK_OFF, 32'h0);
    check(rd & 32'h1FFF, 32'h123);
    ret(RRSE_OP_RET_SUB, 8'h00);
    check(rd, 32'h123);
    apb(1'b0, RRSE_STATUS_OFF, 32'h0);
    check(rd, 32'hF);
  endtask : t_returns

  // a write landing inside the busy window must be refused, just after it accepted
  task automatic probe(input rrse_op_t op, input int n, input logic e);
    // stack words are unknown after reset, so give every pop a known word
    apb(1'b1, RRSE_STACK_OFF, 32'h0ABC);
    apb(1'b1, RRSE_CTRL_OFF, {1'b1, 12'h0, op, 1'b1, 7'h10, 8'h00});
    repeat (n) @(posedge sys_clk);
    apb(1'b1, RRSE_ACC_OFF, 32'h5A);
    check(err, e);
    wait_idle();
  endtask : probe

  task automatic t_sleep;
    int n;
    repeat (65600) @(posedge sys_clk);
    apb(1'b0, RRSE_STATUS_OFF, 32'h0);
    check(rd & 32'h8, 32'h0);
    apb(1'b1, RRSE_STATUS_OFF, 32'h2);
    apb(1'b1, RRSE_ACC_OFF, 32'h77);
    apb(1'b1, RRSE_CTRL_OFF, {1'b1, 12'h0, RRSE_OP_POWER_DOWN, 16'h0});
    phases();
    n = 0;
    while (sleeping !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    check(sleeping, 1'b1);
    apb(1'b0, RRSE_WDOG_OFF, 32'h0);
    check(rd & 32'hFFC0, 32'h0);
    apb(1'b0, RRSE_STATUS_OFF, 32'h0);
    check(rd, 32'h3A);
    repeat (8) begin
      @(negedge sys_clk);
      check({sleeping, phase}, 3'h4);
    end
    apb(1'b0, RRSE_ACC_OFF, 32'h0);
    check(rd, 32'h77);
    @(posedge sys_clk);
    wake_req <= 1'b1;
    n = 0;
    while (sleeping !== 1'b0 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    wake_req <= 1'b0;
    check(sleeping, 1'b0);
    apb(1'b0, RRSE_STATUS_OFF, 32'h0);
    check(rd & 32'h4, 32'h0);
  endtask : t_sleep

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wake_req = 1'b0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_rotate();
    t_returns();
    probe(RRSE_OP_RET_SUB, 5, 1'b1);
    probe(RRSE_OP_RET_LIT, 6, 1'b0);
    probe(RRSE_OP_RET_INT, 5, 1'b1);
    probe(RRSE_OP_ROT_LEFT, 1, 1'b1);
    probe(RRSE_OP_ROT_RIGHT, 2, 1'b0);
    probe(RRSE_OP_NOP, 1, 1'b1);
    t_sleep();
    report_and_stop();
  end
endmodule : test_return_rotate_sleep_exec
